// >>> rtl/flash_bus_cycle.sv
`timescale 1ns/100ps
// one read or write cycle on the flash pins; enables return high between cycles
module flash_bus_cycle
   import flash_poll_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic write_i,
   input wire logic [23:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic [15:0] dq_i,
   output logic done_o,
   output logic [15:0] rdata_o,
   output logic [23:0] addr_o,
   output logic [15:0] dq_o,
   output logic dq_oe_o,
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o
);
   typedef enum {C_IDLE, C_ACT, C_GAP} cyc_t;
   cyc_t st_reg;
   logic [3:0] cnt_reg;

   // ********************************
   // pin sequencer
   // ********************************
   // every cycle ends with ce and oe high so the next read is fresh
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st_reg <= C_IDLE;
         cnt_reg <= 4'h0;
         done_o <= 1'b0;
         rdata_o <= 16'h0000;
         addr_o <= 24'h00_0000;
         dq_o <= 16'h0000;
         dq_oe_o <= 1'b0;
         ce_n_o <= 1'b1;
         oe_n_o <= 1'b1;
         we_n_o <= 1'b1;
      end else if (ce_i) begin
         done_o <= 1'b0;
         case (st_reg)
            C_IDLE: begin
               if (start_i) begin
                  st_reg <= C_ACT;
                  cnt_reg <= ACCESS_CNT;
                  addr_o <= addr_i;
                  dq_o <= wdata_i;
                  dq_oe_o <= write_i;
                  ce_n_o <= 1'b0;
                  oe_n_o <= write_i;
                  we_n_o <= !write_i;
               end
            end
            C_ACT: begin
               if (cnt_reg == 4'h1) begin
                  if (oe_n_o == 1'b0) begin
                     rdata_o <= dq_i;
                  end
                  ce_n_o <= 1'b1;
                  oe_n_o <= 1'b1;
                  we_n_o <= 1'b1;
                  st_reg <= C_GAP;
                  cnt_reg <= GAP_CNT;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            C_GAP: begin
               dq_oe_o <= 1'b0;
               if (cnt_reg == 4'h1) begin
                  st_reg <= C_IDLE;
                  done_o <= 1'b1;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            default: st_reg <= C_IDLE;
         endcase
      end
   end

   a_fresh_access: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (done_o |-> ce_n_o && oe_n_o))
      else $error("flash enables low at end of cycle");
endmodule

// >>> rtl/flash_poll_ctrl.sv
`timescale 1ns/100ps
// Behaviour
// - host toggles ce/oe between reads so each read is fresh
// - host reads status twice and compares toggle bits; equal means done
// - toggling with bit 5 high: recheck, then write reset if still toggling
// - resumed polling restarts from the initial double read; here each further read is compared with the read before it
// - after timing failure host writes the reset command
// - host may skip bit 3 checks if commands spaced within the window
// - host confirms erase start, then checks bit 3 around sector commands; here only the last read's bit 3 is kept if window check is set
// - bit 1 high on buffer abort; host issues abort reset sequence
module flash_poll_ctrl
   import flash_poll_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic RESETN_I,
   input wire logic CE_I,
   input wire logic [7:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic [7:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   output logic [23:0] FLASH_ADDR_O,
   input wire logic [15:0] FLASH_DQ_I,
   output logic [15:0] FLASH_DQ_O,
   output logic FLASH_DQ_OE_O,
   output logic FLASH_CE_N_O,
   output logic FLASH_OE_N_O,
   output logic FLASH_WE_N_O
);
   typedef enum {P_IDLE, P_READ1, P_READ2, P_RECHECK, P_RESET1, P_RESET2,
      P_RESET3, P_WINDOW} poll_t;

   poll_t st_reg;
   logic [31:0] ctrl_reg;
   logic [23:0] addr_reg;
   logic [31:0] status_reg;
   logic [15:0] first_reg;
   logic [15:0] last_reg;
   logic cyc_start_reg;
   logic cyc_write_reg;
   logic [23:0] cyc_addr_reg;
   logic [15:0] cyc_wdata_reg;
   logic cyc_done;
   logic [15:0] cyc_rdata;
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic start_pulse;

   // toggle bit differs between two reads
   function automatic logic toggling(input logic [15:0] a,
                                     input logic [15:0] b);
      toggling = a[BIT_TOGGLE] != b[BIT_TOGGLE];
   endfunction

   // ********************************
   // AXI4-Lite slave
   // ********************************
   // address and data taken in either order; response once both are held
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         AWREADY_O <= 1'b1;
         WREADY_O <= 1'b1;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         BVALID_O <= 1'b0;
         BRESP_O <= 2'b00;
      end else if (CE_I) begin
         if (AWVALID_I && AWREADY_O) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= AWADDR_I;
            AWREADY_O <= 1'b0;
         end
         if (WVALID_I && WREADY_O) begin
            w_held_reg <= 1'b1;
            w_data_reg <= WDATA_I;
            w_strb_reg <= WSTRB_I;
            WREADY_O <= 1'b0;
         end
         if (aw_held_reg && w_held_reg && !BVALID_O) begin
            BVALID_O <= 1'b1;
            BRESP_O <= (aw_addr_reg == OFF_CTRL ||
               aw_addr_reg == OFF_ADDR) ? 2'b00 : 2'b10;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
         end
         if (BVALID_O && BREADY_I) begin
            BVALID_O <= 1'b0;
            AWREADY_O <= 1'b1;
            WREADY_O <= 1'b1;
         end
      end
   end

   assign start_pulse = CE_I && aw_held_reg && w_held_reg && !BVALID_O &&
      aw_addr_reg == OFF_CTRL && w_strb_reg[0] && w_data_reg[CTRL_START];

   // writable registers; start bit self-clears
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         ctrl_reg <= 32'h0000_0000;
         addr_reg <= 24'h00_0000;
      end else if (CE_I) begin
         if (aw_held_reg && w_held_reg && !BVALID_O) begin
            if (aw_addr_reg == OFF_CTRL && w_strb_reg[0]) begin
               ctrl_reg <= {30'h0000_0000, w_data_reg[CTRL_WINDOW_CHECK],
                  1'b0};
            end
            if (aw_addr_reg == OFF_ADDR) begin
               if (w_strb_reg[0]) addr_reg[7:0] <= w_data_reg[7:0];
               if (w_strb_reg[1]) addr_reg[15:8] <= w_data_reg[15:8];
               if (w_strb_reg[2]) addr_reg[23:16] <= w_data_reg[23:16];
            end
         end
      end
   end

   // read channel, answer one cycle after the address is taken
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         ARREADY_O <= 1'b1;
         RVALID_O <= 1'b0;
         RDATA_O <= 32'h0000_0000;
         RRESP_O <= 2'b00;
      end else if (CE_I) begin
         if (ARVALID_I && ARREADY_O) begin
            ARREADY_O <= 1'b0;
            RVALID_O <= 1'b1;
            RRESP_O <= 2'b00;
            case (ARADDR_I)
               OFF_CTRL: RDATA_O <= ctrl_reg;
               OFF_ADDR: RDATA_O <= {8'h00, addr_reg};
               OFF_STATUS: RDATA_O <= status_reg;
               OFF_LAST: RDATA_O <= {16'h0000, last_reg};
               default: begin
                  RDATA_O <= 32'h0000_0000;
                  RRESP_O <= 2'b10;
               end
            endcase
         end else if (RVALID_O && RREADY_I) begin
            RVALID_O <= 1'b0;
            ARREADY_O <= 1'b1;
         end
      end
   end

   // ********************************
   // polling engine
   // ********************************
   // a new start always begins at the first of the double read
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         st_reg <= P_IDLE;
         status_reg <= STATUS_RESET;
         first_reg <= 16'h0000;
         last_reg <= 16'h0000;
         cyc_start_reg <= 1'b0;
         cyc_write_reg <= 1'b0;
         cyc_addr_reg <= 24'h00_0000;
         cyc_wdata_reg <= 16'h0000;
      end else if (CE_I) begin
         cyc_start_reg <= 1'b0;
         case (st_reg)
            P_IDLE: begin
               if (start_pulse) begin
                  status_reg <= 32'h0000_0001;
                  st_reg <= P_READ1;
                  cyc_start_reg <= 1'b1;
                  cyc_write_reg <= 1'b0;
                  cyc_addr_reg <= addr_reg;
               end
            end
            P_READ1: begin
               if (cyc_done) begin
                  first_reg <= cyc_rdata;
                  last_reg <= cyc_rdata;
                  st_reg <= P_READ2;
                  cyc_start_reg <= 1'b1;
               end
            end
            P_READ2, P_RECHECK: begin
               if (cyc_done) begin
                  last_reg <= cyc_rdata;
                  first_reg <= cyc_rdata;
                  if (!toggling(first_reg, cyc_rdata)) begin
                     // toggle bits equal, operation done; optionally check window
                     // window check is optional, software may skip it
                     if (ctrl_reg[CTRL_WINDOW_CHECK]) begin
                        status_reg[ST_WINDOW_HIGH] <= cyc_rdata[BIT_WINDOW];
                     end
                     status_reg[ST_BUSY] <= 1'b0;
                     status_reg[ST_DONE] <= 1'b1;
                     st_reg <= P_IDLE;
                  end else if (cyc_rdata[BIT_ABORT]) begin
                     status_reg[ST_ABORT] <= 1'b1;
                     st_reg <= P_RESET1;
                     cyc_start_reg <= 1'b1;
                     cyc_write_reg <= 1'b1;
                     cyc_addr_reg <= ADDR_UNLOCK_1;
                     cyc_wdata_reg <= CMD_ABORT_1;
                  end else if (st_reg == P_RECHECK) begin
                     status_reg[ST_FAIL] <= 1'b1;
                     st_reg <= P_RESET3;
                     cyc_start_reg <= 1'b1;
                     cyc_write_reg <= 1'b1;
                     cyc_addr_reg <= addr_reg;
                     cyc_wdata_reg <= CMD_RESET;
                  end else begin
                     st_reg <= cyc_rdata[BIT_FAIL] ? P_RECHECK : P_READ2;
                     cyc_start_reg <= 1'b1;
                  end
               end
            end
            P_RESET1: begin
               if (cyc_done) begin
                  st_reg <= P_RESET2;
                  cyc_start_reg <= 1'b1;
                  cyc_addr_reg <= ADDR_UNLOCK_2;
                  cyc_wdata_reg <= CMD_ABORT_2;
               end
            end
            P_RESET2: begin
               if (cyc_done) begin
                  st_reg <= P_RESET3;
                  cyc_start_reg <= 1'b1;
                  cyc_addr_reg <= ADDR_UNLOCK_1;
                  cyc_wdata_reg <= CMD_ABORT_3;
               end
            end
            P_RESET3: begin
               if (cyc_done) begin
                  cyc_write_reg <= 1'b0;
                  status_reg[ST_BUSY] <= 1'b0;
                  st_reg <= P_IDLE;
               end
            end
            default: st_reg <= P_IDLE;
         endcase
      end
   end

   flash_bus_cycle u_cycle (
      .clk_i(SYS_CLK_I),
      .resetn_i(RESETN_I),
      .ce_i(CE_I),
      .start_i(cyc_start_reg),
      .write_i(cyc_write_reg),
      .addr_i(cyc_addr_reg),
      .wdata_i(cyc_wdata_reg),
      .dq_i(FLASH_DQ_I),
      .done_o(cyc_done),
      .rdata_o(cyc_rdata),
      .addr_o(FLASH_ADDR_O),
      .dq_o(FLASH_DQ_O),
      .dq_oe_o(FLASH_DQ_OE_O),
      .ce_n_o(FLASH_CE_N_O),
      .oe_n_o(FLASH_OE_N_O),
      .we_n_o(FLASH_WE_N_O)
   );

   a_done_on_equal: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESETN_I)
      (CE_I && st_reg == P_READ2 && cyc_done &&
       !toggling(first_reg, cyc_rdata) |=> st_reg == P_IDLE &&
       status_reg[ST_DONE]))
      else $error("polling did not end on equal toggle bits");

   a_fail_recheck: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESETN_I)
      (CE_I && st_reg == P_READ2 && cyc_done && !cyc_rdata[BIT_ABORT] &&
       toggling(first_reg, cyc_rdata) && cyc_rdata[BIT_FAIL]
       |=> st_reg == P_RECHECK))
      else $error("no recheck after failure bit");

   a_reset_write: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESETN_I)
      ($rose(status_reg[ST_FAIL]) |-> st_reg == P_RESET3 &&
       cyc_wdata_reg == CMD_RESET && cyc_write_reg))
      else $error("reset command not issued after failure");

   a_abort_seq: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESETN_I)
      ($rose(status_reg[ST_ABORT]) |-> st_reg == P_RESET1 &&
       cyc_wdata_reg == CMD_ABORT_1))
      else $error("abort reset sequence not started");

   // start always begins with a first read
   a_restart_read: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESETN_I)
      (st_reg == P_IDLE && start_pulse |=> st_reg == P_READ1 &&
       cyc_start_reg && !cyc_write_reg))
      else $error("polling did not restart at double read");

   // flash enables released before next read
   a_enables_gap: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESETN_I)
      (cyc_start_reg |-> FLASH_CE_N_O && FLASH_OE_N_O))
      else $error("new read started without enable release");

   // write response comes one cycle after both halves are held
   a_bresp_time: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESETN_I)
      (CE_I && aw_held_reg && w_held_reg && !BVALID_O |=> BVALID_O))
      else $error("write response late");

   // read answer one cycle after address
   a_rresp_time: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESETN_I)
      (CE_I && ARVALID_I && ARREADY_O |=> RVALID_O))
      else $error("read answer late");
endmodule

// >>> rtl/flash_poll_pkg.sv
package flash_poll_pkg;
   // ********************************
   // status bit positions on the data bus
   // ********************************
   localparam int BIT_POLL = 7;
   localparam int BIT_TOGGLE = 6;
   localparam int BIT_FAIL = 5;
   localparam int BIT_WINDOW = 3;
   localparam int BIT_SECTOR_TOGGLE = 2;
   localparam int BIT_ABORT = 1;

   // ********************************
   // flash command words
   // ********************************
   localparam logic [15:0] CMD_RESET = 16'h00F0;
   localparam logic [15:0] CMD_ABORT_1 = 16'h00AA;
   localparam logic [15:0] CMD_ABORT_2 = 16'h0055;
   localparam logic [15:0] CMD_ABORT_3 = 16'h00F0;
   localparam logic [23:0] ADDR_UNLOCK_1 = 24'h00_0555;
   localparam logic [23:0] ADDR_UNLOCK_2 = 24'h00_02AA;

   // ********************************
   // controller register map (byte offsets)
   // ********************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ADDR = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_LAST = 8'h0C;
   localparam int CTRL_START = 0;
   localparam int CTRL_WINDOW_CHECK = 1;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAIL = 2;
   localparam int ST_ABORT = 3;
   localparam int ST_WINDOW_HIGH = 4;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

   // ********************************
   // pin timing
   // ********************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int ACCESS_TIME_NS = 70;
   localparam int ACCESS_CYCLES =
      (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_TIME_NS = 30;
   localparam int GAP_CYCLES =
      (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] ACCESS_CNT = 4'(ACCESS_CYCLES);
   localparam logic [3:0] GAP_CNT = 4'(GAP_CYCLES);
endpackage

// >>> tb/flash_dev_model.sv
`timescale 1ns/100ps
// ****
// behavioural flash die: mode 0 program, 1 erase, 2 fail, 3 abort
// ****
module flash_dev_model
   import flash_poll_pkg::*;
#(
   parameter logic [15:0] ARRAY_WORD = 16'h5A3C
)
(
   input wire logic [23:0] addr_i,
   input wire logic [15:0] dq_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic arm_i,
   input wire logic [1:0] mode_i,
   input wire logic [3:0] polls_i,
   output logic [15:0] dq_o,
   output int wr_cnt_o,
   output logic [23:0] wr_addr_o,
   output logic [15:0] wr_data_o,
   output logic [23:0] rd_addr_o
);
   logic busy;
   logic tgl;
   logic rd;
   logic [3:0] left;
   logic [15:0] word;
   int seq;
   initial begin
      busy = 1'b0;
      tgl = 1'b0;
      left = 4'h0;
      word = 16'h0000;
      seq = 0;
      wr_cnt_o = 0;
   end
   assign rd = !ce_n_i && !oe_n_i;
   // a released bus shows the inverse of the last word, never a stale copy
   assign dq_o = rd ? word : ~word;
   // an operation is armed by the bench before the controller starts
   always @(posedge arm_i) begin
      busy = 1'b1;
      left = polls_i;
   end
   // one status or array word per fresh access
   always @(posedge rd) begin
      // the address is only logged; every address reads status while busy
      rd_addr_o = addr_i;
      if (busy) begin
         // a protected-sector program is mode 0 with a short count
         tgl = ~tgl;
         word = 16'h0000;
         word[BIT_POLL] = (mode_i == 2'd1) ? 1'b0 : ~ARRAY_WORD[BIT_POLL];
         word[BIT_TOGGLE] = tgl;
         word[BIT_FAIL] = (mode_i == 2'd2);
         word[BIT_WINDOW] = (mode_i == 2'd1);
         word[BIT_SECTOR_TOGGLE] = (mode_i == 2'd1) & tgl;
         word[BIT_ABORT] = (mode_i == 2'd3);
         if (mode_i < 2'd2) begin
            left = left - 4'h1;
            if (left == 4'h0) busy = 1'b0;
         end
      end else begin
         word = ARRAY_WORD;
      end
   end
   // writes are logged so the bench can check the command words
   always @(posedge we_n_i) begin
      wr_cnt_o = wr_cnt_o + 1;
      wr_addr_o = addr_i;
      wr_data_o = dq_i;
      if (mode_i == 2'd2 && dq_i == CMD_RESET) busy = 1'b0;
      if (dq_i == CMD_ABORT_1) seq = 1;
      else if (seq == 1 && dq_i == CMD_ABORT_2) seq = 2;
      else begin
         if (seq == 2 && dq_i == CMD_ABORT_3 && mode_i == 2'd3) busy = 1'b0;
         seq = 0;
      end
   end
endmodule

// >>> tb/flash_poll_ctrl_tb.sv
`timescale 1ns/100ps
module flash_poll_ctrl_tb;
   import flash_poll_pkg::*;
   localparam logic [15:0] ARRAY_WORD = 16'h5A3C;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, arm = 1'b0;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [3:0] wstrb = 4'h0, polls = 4'h1;
   logic awready, wready, bvalid, arready, rvalid, dq_oe, ce_n, oe_n, we_n;
   logic [1:0] bresp, rresp, mode = 2'h0;
   logic [23:0] faddr, wr_addr, rd_addr;
   logic [15:0] dq_in, dq_out, wr_data;
   int wr_cnt;
   int err_total = 0;
   int checked = 0;
   // ****
   // design and far side
   // ****
   flash_poll_ctrl u_flash_poll_ctrl (
      .SYS_CLK_I(clk), .RESETN_I(resetn), .CE_I(ce),
      .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
      .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
      .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
      .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
      .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
      .RVALID_O(rvalid), .RREADY_I(rready), .FLASH_ADDR_O(faddr),
      .FLASH_DQ_I(dq_in), .FLASH_DQ_O(dq_out), .FLASH_DQ_OE_O(dq_oe),
      .FLASH_CE_N_O(ce_n), .FLASH_OE_N_O(oe_n), .FLASH_WE_N_O(we_n));
   flash_dev_model #(.ARRAY_WORD(ARRAY_WORD)) u_flash_dev_model (
      .addr_i(faddr), .dq_i(dq_out), .ce_n_i(ce_n), .oe_n_i(oe_n),
      .we_n_i(we_n), .arm_i(arm), .mode_i(mode), .polls_i(polls),
      .dq_o(dq_in), .wr_cnt_o(wr_cnt), .wr_addr_o(wr_addr),
      .wr_data_o(wr_data), .rd_addr_o(rd_addr));
   initial forever #5 clk = ~clk;
   // ****
   // shared tasks
   // ****
   task compare(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      $display("%0d comparisons, %0d mismatches", checked, err_total);
      if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // an extra edge at the end keeps back-to-back calls from clashing
   task axi_wr(input logic [7:0] a, input logic [31:0] d,
               input logic [3:0] s, output logic [1:0] r);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task axi_rd(input logic [7:0] a, output logic [31:0] d,
               output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask
   // one polling run against the model in mode m
   task run_poll(input int m);
      logic [31:0] st, d, a;
      logic [1:0] r;
      int base;
      a = $urandom & 32'h00FF_FFFF;
      axi_wr(OFF_ADDR, a, 4'hF, r);
      mode <= 2'(m);
      polls <= 4'($urandom_range(1, 6));
      arm <= 1'b1;
      @(posedge clk);
      arm <= 1'b0;
      base = wr_cnt;
      axi_wr(OFF_CTRL, (m == 1) ? 32'h3 : 32'h1, 4'hF, r);
      // random clock-enable stalls stretch the flash cycles
      do begin
         if ($urandom_range(0, 3) == 0) begin
            ce <= 1'b0;
            repeat ($urandom_range(1, 20)) @(posedge clk);
            ce <= 1'b1;
         end
         axi_rd(OFF_STATUS, st, r);
      end while (st[ST_BUSY] !== 1'b0);
      case (m)
         0: compare(st, 32'h2);
         1: compare(st, {27'h0, ARRAY_WORD[3], 4'h2});
         2: compare(st, 32'h4);
         default: compare(st, 32'h8);
      endcase
      compare(32'(rd_addr), a);
      if (m < 2) begin
         axi_rd(OFF_LAST, d, r);
         compare(d, {16'h0000, ARRAY_WORD});
         compare(32'(wr_cnt - base), 32'h0);
      end else if (m == 2) begin
         compare(32'(wr_cnt - base), 32'h1);
         compare(32'(wr_data), 32'(CMD_RESET));
         compare(32'(wr_addr), a);
      end else begin
         compare(32'(wr_cnt - base), 32'h3);
         compare(32'(wr_data), 32'(CMD_ABORT_3));
         compare(32'(wr_addr), 32'(ADDR_UNLOCK_1));
      end
      axi_rd(OFF_CTRL, d, r);
      compare(d, (m == 1) ? 32'h2 : 32'h0);
      $display("poll test in mode %0d finished", m);
   endtask
   // ****
   // main sequence and watchdog
   // ****
   initial begin
      logic [31:0] d, a;
      logic [1:0] r;
      void'($urandom(25));
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      compare(32'({ce_n, oe_n, we_n, dq_oe}), 32'hE);
      // reset values, then one unmapped offset
      for (int i = 0; i < 5; i++) begin
         axi_rd(8'(i * 4), d, r);
         compare(d, 32'h0);
         compare(32'(r), (i < 4) ? 32'h0 : 32'h2);
      end
      axi_wr(OFF_STATUS, 32'hFFFF_FFFF, 4'hF, r);
      compare(32'(r), 32'h2);
      a = $urandom;
      axi_wr(OFF_ADDR, a, 4'hF, r);
      axi_wr(OFF_ADDR, ~a, 4'h2, r);
      axi_rd(OFF_ADDR, d, r);
      compare(d, {8'h00, a[23:16], ~a[15:8], a[7:0]});
      $display("register test finished");
      for (int m = 0; m < 4; m++) run_poll(m);
      repeat (6) run_poll($urandom_range(0, 3));
      end_of_test;
   end
   // the whole run needs well under a tenth of this span
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      end_of_test;
   end
endmodule
